// >>> egpio_regs.svh
`ifndef EGPIO_REGS_SVH
`define EGPIO_REGS_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define EGPIO_IDX_P1_MODE 24'hffffd0
`define EGPIO_IDX_P2_MODE 24'hffffd1
`define EGPIO_IDX_P1_DIR 24'hfffff0
`define EGPIO_IDX_P2_DIR 24'hfffff1
`define EGPIO_IDX_P1_DATA 24'hffffe0
`define EGPIO_IDX_P2_DATA 24'hffffe1
`define EGPIO_IDX_P1_PULLUP 24'hff0010
`define EGPIO_IDX_P2_PULLUP 24'hff0011
`define EGPIO_IDX_P1_DRIVE 24'hff0030
`define EGPIO_IDX_P2_DRIVE 24'hff0031

// ----------------------------------------
// Storage slots of the register file
// ----------------------------------------
`define EGPIO_NREG 10
`define EGPIO_SLOT_P1_MODE 4'h0
`define EGPIO_SLOT_P2_MODE 4'h1
`define EGPIO_SLOT_P1_DIR 4'h2
`define EGPIO_SLOT_P2_DIR 4'h3
`define EGPIO_SLOT_P1_DATA 4'h4
`define EGPIO_SLOT_P2_DATA 4'h5
`define EGPIO_SLOT_P1_PULLUP 4'h6
`define EGPIO_SLOT_P2_PULLUP 4'h7
`define EGPIO_SLOT_P1_DRIVE 4'h8
`define EGPIO_SLOT_P2_DRIVE 4'h9
`define EGPIO_SLOT_LAST 4'h9
`define EGPIO_SLOT_NONE 4'hf

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define EGPIO_REG_RST 8'h00
`define EGPIO_RDATA_RST 32'h0000_0000
`define EGPIO_RESP_OKAY 1'b0

`endif

// >>> egpio_pkg.sv
`default_nettype none
`include "egpio_regs.svh"

package egpio_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [7:0] egpio_byte_t;
  typedef logic [`EGPIO_NREG-1:0][7:0] egpio_regfile_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_WRITE = 2'b10
  } egpio_phase_t;

  typedef struct packed {
    egpio_phase_t phase;
    logic [3:0] wslot;
    egpio_regfile_t regs;
    logic [1:0][7:0] samp;
    logic [31:0] rdata;
  } egpio_state_t;

endpackage

`default_nettype wire

// >>> egpio_pin_mux.sv
`timescale 1ns/100ps
`default_nettype none

module egpio_pin_mux (
  // Register bits of one port
  input wire egpio_pkg::egpio_byte_t mode,
  input wire egpio_pkg::egpio_byte_t dir,
  input wire egpio_pkg::egpio_byte_t data,
  input wire egpio_pkg::egpio_byte_t pull_en,
  input wire egpio_pkg::egpio_byte_t drive,
  // Mapped peripheral side
  input wire egpio_pkg::egpio_byte_t periph_out,
  input wire egpio_pkg::egpio_byte_t periph_oe,
  // Pad side
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pullup_on,
  output logic [7:0] drive_high
);
  import egpio_pkg::*;

  // ----------------------------------------
  // Per-pin routing, bit n serves pin n
  // ----------------------------------------
  assign pin_out = (mode & periph_out) | (~mode & data);
  assign pin_oe = (mode & periph_oe) | (~mode & dir);
  // Pull-up only on pins that are not being driven, general or mapped input
  assign pullup_on = pull_en & ~pin_oe;
  assign drive_high = drive;

endmodule

`default_nettype wire

// >>> egpio_port_pair.sv
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "egpio_regs.svh"

module egpio_port_pair (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Port 1 pads
  input wire egpio_pkg::egpio_byte_t p1_pin_in,
  output logic [7:0] p1_pin_out,
  output logic [7:0] p1_pin_oe,
  output logic [7:0] p1_pullup_on,
  output logic [7:0] p1_drive_high,
  // Port 2 pads
  input wire egpio_pkg::egpio_byte_t p2_pin_in,
  output logic [7:0] p2_pin_out,
  output logic [7:0] p2_pin_oe,
  output logic [7:0] p2_pullup_on,
  output logic [7:0] p2_drive_high,
  // Peripheral mapping controller, port 1
  input wire egpio_pkg::egpio_byte_t p1_periph_out,
  input wire egpio_pkg::egpio_byte_t p1_periph_oe,
  output logic [7:0] p1_periph_in,
  // Peripheral mapping controller, port 2
  input wire egpio_pkg::egpio_byte_t p2_periph_out,
  input wire egpio_pkg::egpio_byte_t p2_periph_oe,
  output logic [7:0] p2_periph_in
);
  import egpio_pkg::*;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [3:0] egpio_decode(input logic [31:0] a);
    logic [23:0] idx;
    idx = a[25:2];
    egpio_decode = `EGPIO_SLOT_NONE;
    if (a[31:26] == 6'h00 && a[1:0] == 2'b00) begin
      case (idx)
        `EGPIO_IDX_P1_MODE: egpio_decode = `EGPIO_SLOT_P1_MODE;
        `EGPIO_IDX_P2_MODE: egpio_decode = `EGPIO_SLOT_P2_MODE;
        `EGPIO_IDX_P1_DIR: egpio_decode = `EGPIO_SLOT_P1_DIR;
        `EGPIO_IDX_P2_DIR: egpio_decode = `EGPIO_SLOT_P2_DIR;
        `EGPIO_IDX_P1_DATA: egpio_decode = `EGPIO_SLOT_P1_DATA;
        `EGPIO_IDX_P2_DATA: egpio_decode = `EGPIO_SLOT_P2_DATA;
        `EGPIO_IDX_P1_PULLUP: egpio_decode = `EGPIO_SLOT_P1_PULLUP;
        `EGPIO_IDX_P2_PULLUP: egpio_decode = `EGPIO_SLOT_P2_PULLUP;
        `EGPIO_IDX_P1_DRIVE: egpio_decode = `EGPIO_SLOT_P1_DRIVE;
        `EGPIO_IDX_P2_DRIVE: egpio_decode = `EGPIO_SLOT_P2_DRIVE;
        default: egpio_decode = `EGPIO_SLOT_NONE;
      endcase
    end
  endfunction

  // Output pins give back the stored bit, input pins the sampled level
  function automatic egpio_byte_t egpio_merge(input egpio_byte_t dir, input egpio_byte_t data,
                                              input egpio_byte_t samp);
    egpio_merge = (dir & data) | (~dir & samp);
  endfunction

  function automatic egpio_byte_t egpio_read(input logic [3:0] slot, input egpio_regfile_t regs,
                                             input logic [1:0][7:0] samp);
    egpio_read = 8'h00;
    case (slot)
      `EGPIO_SLOT_P1_DATA: begin
        egpio_read = egpio_merge(regs[`EGPIO_SLOT_P1_DIR], regs[`EGPIO_SLOT_P1_DATA], samp[0]);
      end
      `EGPIO_SLOT_P2_DATA: begin
        egpio_read = egpio_merge(regs[`EGPIO_SLOT_P2_DIR], regs[`EGPIO_SLOT_P2_DATA], samp[1]);
      end
      `EGPIO_SLOT_NONE: begin
        egpio_read = 8'h00;
      end
      default: begin
        if (slot <= `EGPIO_SLOT_LAST) begin
          egpio_read = regs[slot];
        end
      end
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  egpio_state_t st_r;
  egpio_state_t st_nxt;
  logic addr_ph;
  logic [3:0] aslot;
  logic [1:0][7:0] pin_out_v;
  logic [1:0][7:0] pin_oe_v;
  logic [1:0][7:0] pull_v;
  logic [1:0][7:0] drv_v;
  logic [1:0][7:0] per_out_v;
  logic [1:0][7:0] per_oe_v;

  assign addr_ph = hsel && hready && htrans[1];
  assign aslot = egpio_decode(haddr);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // A read issued right behind a write to the same register sees the new
  // value, since it is taken from the updated copy rather than from st_r.
  always_comb begin
    st_nxt = st_r;
    // Pins are synchronous, one sampling stage for readback and peripherals
    st_nxt.samp = {p2_pin_in, p1_pin_in};
    if (st_r.phase == PH_WRITE && st_r.wslot <= `EGPIO_SLOT_LAST) begin
      st_nxt.regs[st_r.wslot] = hwdata[7:0];
    end
    st_nxt.phase = PH_IDLE;
    st_nxt.wslot = `EGPIO_SLOT_NONE;
    if (addr_ph) begin
      if (hwrite) begin
        st_nxt.phase = PH_WRITE;
        st_nxt.wslot = aslot;
      end else begin
        st_nxt.rdata = {24'h00_0000, egpio_read(aslot, st_nxt.regs, st_r.samp)};
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.phase <= PH_IDLE;
      st_r.wslot <= `EGPIO_SLOT_NONE;
      st_r.regs <= {`EGPIO_NREG{`EGPIO_REG_RST}};
      st_r.samp <= {2{8'h00}};
      st_r.rdata <= `EGPIO_RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  // Zero wait states: reads are prepared during the address phase
  assign hreadyout = 1'b1;
  assign hresp = `EGPIO_RESP_OKAY;
  assign hrdata = st_r.rdata;

  // ----------------------------------------
  // Pin routing per port
  // ----------------------------------------
  assign per_out_v = {p2_periph_out, p1_periph_out};
  assign per_oe_v = {p2_periph_oe, p1_periph_oe};

  for (genvar p = 0; p < 2; p++) begin : g_port
    egpio_pin_mux u_mux (
      .mode(st_r.regs[`EGPIO_SLOT_P1_MODE + p]),
      .dir(st_r.regs[`EGPIO_SLOT_P1_DIR + p]),
      .data(st_r.regs[`EGPIO_SLOT_P1_DATA + p]),
      .pull_en(st_r.regs[`EGPIO_SLOT_P1_PULLUP + p]),
      .drive(st_r.regs[`EGPIO_SLOT_P1_DRIVE + p]),
      .periph_out(per_out_v[p]),
      .periph_oe(per_oe_v[p]),
      .pin_out(pin_out_v[p]),
      .pin_oe(pin_oe_v[p]),
      .pullup_on(pull_v[p]),
      .drive_high(drv_v[p])
    );
  end

  assign p1_pin_out = pin_out_v[0];
  assign p1_pin_oe = pin_oe_v[0];
  assign p1_pullup_on = pull_v[0];
  assign p1_drive_high = drv_v[0];
  assign p2_pin_out = pin_out_v[1];
  assign p2_pin_oe = pin_oe_v[1];
  assign p2_pullup_on = pull_v[1];
  assign p2_drive_high = drv_v[1];
  // Peripherals see the sampled level whatever the mode; the controller decides use
  assign p1_periph_in = st_r.samp[0];
  assign p2_periph_in = st_r.samp[1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [7:0] p1_mode;
  logic [7:0] p1_dir;
  logic [7:0] p1_data;
  logic [7:0] p1_pull;
  logic [7:0] p2_mode;
  logic [7:0] p2_dir;
  assign p1_mode = st_r.regs[`EGPIO_SLOT_P1_MODE];
  assign p1_dir = st_r.regs[`EGPIO_SLOT_P1_DIR];
  assign p1_data = st_r.regs[`EGPIO_SLOT_P1_DATA];
  assign p1_pull = st_r.regs[`EGPIO_SLOT_P1_PULLUP];
  assign p2_mode = st_r.regs[`EGPIO_SLOT_P2_MODE];
  assign p2_dir = st_r.regs[`EGPIO_SLOT_P2_DIR];

  sequence rd_p1_data_s;
    addr_ph && !hwrite && aslot == `EGPIO_SLOT_P1_DATA && st_r.phase == PH_IDLE;
  endsequence

  sequence wr_p1_drive_s;
    addr_ph && hwrite && aslot == `EGPIO_SLOT_P1_DRIVE ##1 1'b1;
  endsequence

  sequence wr_p2_dir_s;
    addr_ph && hwrite && aslot == `EGPIO_SLOT_P2_DIR ##1 !addr_ph;
  endsequence

  drive_from_data_a: assert property (((p1_pin_out ^ p1_data) & p1_dir & ~p1_mode) == 8'h00)
    else $error("output pin does not follow stored data");

  read_stored_a: assert property (rd_p1_data_s |=>
    ((hrdata[7:0] ^ $past(p1_data)) & $past(p1_dir)) == 8'h00)
    else $error("output pin read does not return stored data");

  read_pin_a: assert property (rd_p1_data_s |=>
    ((hrdata[7:0] ^ $past(st_r.samp[0])) & ~$past(p1_dir)) == 8'h00)
    else $error("input pin read does not return pin level");

  pullup_off_a: assert property ((p1_pullup_on & ~p1_pull) == 8'h00)
    else $error("pull-up on while its bit is clear");

  pullup_input_a: assert property (((p1_pullup_on ^ p1_pull) & ~p1_pin_oe) == 8'h00 &&
    (p1_pullup_on & p1_pin_oe) == 8'h00)
    else $error("pull-up wrong for input or output pin");

  drive_select_a: assert property (wr_p1_drive_s |=> p1_drive_high == $past(hwdata[7:0]))
    else $error("drive strength does not follow register write");

  periph_route_a: assert property (((p2_pin_oe ^ p2_periph_oe) & p2_mode) == 8'h00 &&
    ((p2_pin_out ^ p2_periph_out) & p2_mode) == 8'h00)
    else $error("mapped pin not routed to peripheral");

  dir_output_a: assert property (((p2_pin_oe ^ p2_dir) & ~p2_mode) == 8'h00)
    else $error("general pin direction mismatch");

  dir_per_bit_a: assert property (wr_p2_dir_s |=>
    ((p2_pin_oe ^ $past(hwdata[7:0])) & ~p2_mode) == 8'h00)
    else $error("direction write did not act bit by bit");

  reset_input_a: assert property (@(posedge hclk) disable iff (1'b0)
    !hresetn |-> p1_pin_oe == 8'h00 && p2_pin_oe == 8'h00)
    else $error("pin driven during reset");

  reset_zero_a: assert property (@(posedge hclk) disable iff (1'b0)
    $rose(hresetn) |-> st_r.regs == {`EGPIO_NREG{8'h00}} && hrdata == 32'h0000_0000)
    else $error("register not zero after reset");

endmodule

`default_nettype wire

// >>> egpio_pad_model.sv
`timescale 1ns/100ps
`default_nettype none

module egpio_pad_model (
  // Clock
  input wire logic hclk,
  // Pad side of one port
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_on,
  // Outside source on each pin
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Level seen at the pad input
  output logic [7:0] pin_in
);
  logic [7:0] last_r = 8'h00;

  // ----------------------------------------
  // Pin level
  // ----------------------------------------
  always_ff @(posedge hclk) begin
    last_r <= pin_in;
  end

  // A pin nobody drives or pulls shows the inverse of its last level, so no stale value passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pullup_on[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = ~last_r[i];
    end
  end
endmodule

`default_nettype wire

// >>> test_eight_bit_gpio_port_pair.sv
`timescale 1ns/100ps
`default_nettype none
`include "egpio_regs.svh"

module test_eight_bit_gpio_port_pair;
  import egpio_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] p1_in, p1_out, p1_oe, p1_pu, p1_dh, p1_pout, p1_poe, p1_pin;
  logic [7:0] p2_in, p2_out, p2_oe, p2_pu, p2_dh, p2_pout, p2_poe, p2_pin;
  logic [7:0] ext1_en, ext1_val, ext2_en, ext2_val;
  logic [23:0] regs [10];
  int failures;
  int cmp_count;

  // ----------------------------------------
  // Design and pads
  // ----------------------------------------
  egpio_port_pair i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe),
    .p1_pullup_on(p1_pu), .p1_drive_high(p1_dh), .p2_pin_in(p2_in), .p2_pin_out(p2_out),
    .p2_pin_oe(p2_oe), .p2_pullup_on(p2_pu), .p2_drive_high(p2_dh), .p1_periph_out(p1_pout),
    .p1_periph_oe(p1_poe), .p1_periph_in(p1_pin), .p2_periph_out(p2_pout), .p2_periph_oe(p2_poe),
    .p2_periph_in(p2_pin));
  egpio_pad_model i_pad1 (.hclk(hclk), .pin_out(p1_out), .pin_oe(p1_oe), .pullup_on(p1_pu),
    .ext_en(ext1_en), .ext_val(ext1_val), .pin_in(p1_in));
  egpio_pad_model i_pad2 (.hclk(hclk), .pin_out(p2_out), .pin_oe(p2_oe), .pullup_on(p2_pu),
    .ext_en(ext2_en), .ext_val(ext2_val), .pin_in(p2_in));

  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task automatic conclude();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The bus never stalls today, but the bound keeps a broken ready from hanging the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask

  task automatic xfer(input logic wr, input logic [23:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {6'h00, idx, 2'b00};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    wait_rdy();
    rd = hrdata;
    chk("hresp", {31'h00000000, hresp}, 32'h00000000);
  endtask

  task automatic wr(input logic [23:0] idx, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, idx, d, x);
  endtask

  task automatic rd(input logic [23:0] idx, output logic [31:0] d);
    xfer(1'b0, idx, 8'h00, d);
  endtask

  task automatic settle();
    @(posedge hclk);
    #1;
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    htrans <= 2'b00;
    ext1_en <= 8'hff;
    ext1_val <= 8'h00;
    ext2_val <= 8'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    for (int i = 0; i < 10; i++) begin
      rd(regs[i], d);
      chk("register after reset", d, 32'h00000000);
    end
    chk("pin enables after reset", {16'h0000, p1_oe, p2_oe}, 32'h00000000);
    chk("pull-ups after reset", {16'h0000, p1_pu, p2_pu}, 32'h00000000);
  endtask

  task automatic t_output();
    logic [31:0] d;
    ext2_val <= 8'h0f;
    wr(`EGPIO_IDX_P2_DIR, 8'ha5);
    wr(`EGPIO_IDX_P2_DATA, 8'h3c);
    // Read at once: input pins give the outside level, not the stored bits, so read and stored values differ
    rd(`EGPIO_IDX_P2_DATA, d);
    chk("p2 data read", d, 32'h0000002e);
    settle();
    chk("p2 enable", {24'h000000, p2_oe}, 32'h000000a5);
    chk("p1 enable", {24'h000000, p1_oe}, 32'h00000000);
    chk("p2 driven level", {24'h000000, p2_out & 8'ha5}, 32'h00000024);
    @(posedge hclk);
  endtask

  task automatic t_pullup();
    logic [31:0] d;
    ext1_en <= 8'h00;
    wr(`EGPIO_IDX_P1_DIR, 8'he0);
    wr(`EGPIO_IDX_P1_PULLUP, 8'hee);
    wr(`EGPIO_IDX_P1_DRIVE, 8'h6a);
    settle();
    chk("p1 pull-up", {24'h000000, p1_pu}, 32'h0000000e);
    chk("p1 drive", {24'h000000, p1_dh}, 32'h0000006a);
    @(posedge hclk);
    rd(`EGPIO_IDX_P1_PULLUP, d);
    chk("p1 pull-up read", d, 32'h000000ee);
    rd(`EGPIO_IDX_P1_DATA, d);
    chk("p1 pulled data", d & 32'h000000ee, 32'h0000000e);
  endtask

  task automatic t_mapped();
    p2_pout <= 8'h5a;
    p2_poe <= 8'h30;
    wr(`EGPIO_IDX_P2_MODE, 8'hf0);
    wr(`EGPIO_IDX_P2_PULLUP, 8'hff);
    settle();
    chk("mapped enable", {24'h000000, p2_oe}, 32'h00000035);
    chk("mapped level", {24'h000000, p2_out & 8'h35}, 32'h00000014);
    chk("mapped pull-up", {24'h000000, p2_pu}, 32'h000000ca);
    chk("mapped input", {24'h000000, p2_pin & 8'hca}, 32'h0000000a);
    @(posedge hclk);
  endtask

  task automatic t_bus();
    logic [31:0] d;
    p1_pout <= 8'h08;
    p1_poe <= 8'h08;
    wr(24'h000100, 8'hff);
    rd(24'h000100, d);
    chk("unmapped read", d, 32'h00000000);
    wr(`EGPIO_IDX_P2_DRIVE, 8'hff);
    rd(`EGPIO_IDX_P2_DRIVE, d);
    chk("p2 drive read", d, 32'h000000ff);
    wr(`EGPIO_IDX_P1_MODE, 8'h0c);
    rd(`EGPIO_IDX_P1_MODE, d);
    chk("p1 mode read", d, 32'h0000000c);
    chk("p2 drive", {24'h000000, p2_dh}, 32'h000000ff);
    chk("p1 mapped enable", {24'h000000, p1_oe}, 32'h000000e8);
    chk("p1 mapped pull-up", {24'h000000, p1_pu}, 32'h00000006);
    chk("p1 mapped input", {24'h000000, p1_pin & 8'hee}, 32'h0000000e);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    regs = '{`EGPIO_IDX_P1_MODE, `EGPIO_IDX_P2_MODE, `EGPIO_IDX_P1_DIR, `EGPIO_IDX_P2_DIR, `EGPIO_IDX_P1_DATA,
      `EGPIO_IDX_P2_DATA, `EGPIO_IDX_P1_PULLUP, `EGPIO_IDX_P2_PULLUP, `EGPIO_IDX_P1_DRIVE, `EGPIO_IDX_P2_DRIVE};
    failures = 0;
    cmp_count = 0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    hsize = 3'h2;
    p1_pout = 8'h00;
    p1_poe = 8'h00;
    p2_pout = 8'h00;
    p2_poe = 8'h00;
    ext2_en = 8'hff;
    do_reset();
    t_reset();
    t_output();
    t_pullup();
    t_mapped();
    t_bus();
    do_reset();
    t_reset();
    conclude();
  end
endmodule

`default_nettype wire
